// *** logic/flash_host.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_host
   import flash_host_pkg::*;
(
   input wire logic core_clk, // 100 MHz clock
   input wire logic rst_n, // async reset, active low
   input wire logic [3:0] avs_address, // word address
   input wire logic avs_read, // read strobe
   input wire logic avs_write, // write strobe
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   output logic irq, // level interrupt
   output logic [20:0] flash_addr, // address incl. byte lsb
   output logic [7:0] flash_dq_o, // data out
   output logic flash_dq_oe, // data drive enable
   input wire logic [7:0] flash_dq_i, // data in
   output logic flash_ce_n, // chip enable
   output logic flash_oe_n, // output enable
   output logic flash_we_n, // write enable
   output logic hv_ce, // high identifier level on chip enable
   output logic hv_oe, // high identifier level on output enable
   output logic hv_a9 // high identifier level on A9
);
   flash_seq_if s ();
   flash_cmd_rom u_rom (.core_clk(core_clk), .rst_n(rst_n), .s(s));

   state_t state_q, state_d;
   logic [3:0] op_q;
   logic [20:0] addr_q;
   logic [7:0] wdata_q;
   logic [3:0] blkcnt_q;
   logic [3:0] idx_q;
   logic [2:0] tmr_q;
   logic [7:0] rdata_q;
   logic [7:0] prev_q;
   logic [3:0] irq_q;
   logic [3:0] mask_q;
   logic done_q;
   logic err_q;
   logic armed_q;
   logic ack_q;
   logic [7:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_f_q;
   logic busy;
   assign busy = (state_q != st_idle);

   // bus decode
   wire wr_ctrl = avs_write && avs_address == `REG_CTRL;
   wire go = wr_ctrl && avs_writedata[`CTRL_GO] && !busy;
   wire go_refused = wr_ctrl && avs_writedata[`CTRL_GO] && busy;
   wire hit = avs_address <= `REG_MASK;
   // one wait cycle on reads so readdata comes from a flop
   assign avs_waitrequest = avs_read && !ack_q;

   // three-stage sampler, change counts once stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
         dq_s3_q <= 8'h00;
         dq_f_q <= 8'h00;
      end else begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
         dq_s3_q <= dq_s2_q;
         if (dq_s2_q == dq_s3_q)
            dq_f_q <= dq_s3_q;
      end
   end

   wire is_read = op_q == op_read || op_q == op_verify;
   wire is_hv = op_q == op_protect || op_q == op_unprotect;
   wire needs_poll = op_q == op_program || op_q == op_byp_prog ||
      op_q == op_chip_erase || op_q == op_blk_erase || op_q == op_resume;
   wire tmr_zero = tmr_q == 3'd0;
   wire last_step = is_read || is_hv || s.last;
   // extra block addresses stream in as idx grows past five
   wire more_blks = op_q == op_blk_erase && blkcnt_q != 4'd0;
   wire toggling = prev_q[`ST_TOGGLE] != dq_f_q[`ST_TOGGLE];
   wire poll_fail = dq_f_q[`ST_ERROR] && toggling;

   assign s.idx = idx_q;
   assign s.op = op_q;
   assign s.tgt = addr_q;
   assign s.val = wdata_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         st_idle: if (go) state_d = st_setup;
         st_setup: if (tmr_zero) state_d = st_strobe;
         st_strobe: if (tmr_zero) state_d = st_next;
         st_next: state_d = (last_step && !more_blks) ?
            (needs_poll ? st_poll : st_done) : st_setup;
         // status keeps toggling while the controller runs
         // first sample only arms, it has nothing to compare with
         st_poll: if (tmr_zero && armed_q && (!toggling || poll_fail))
            state_d = st_done;
         st_done: state_d = st_idle;
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_idle;
         tmr_q <= 3'd0;
         idx_q <= 4'd0;
         armed_q <= 1'b0;
      end else begin
         state_q <= state_d;
         armed_q <= (state_q == st_poll) && (armed_q || tmr_zero);
         if (state_q != state_d)
            tmr_q <= (state_d == st_strobe || state_d == st_poll) ?
               `T_STROBE : `T_SETUP;
         else if (!tmr_zero)
            tmr_q <= tmr_q - 3'd1;
         else if (state_q == st_poll)
            tmr_q <= `T_STROBE;
         if (state_q == st_idle)
            idx_q <= 4'd0;
         else if (state_q == st_next && idx_q != 4'd15)
            idx_q <= idx_q + 4'd1;
      end
   end

   wire [20:0] vfy_addr = {addr_q[20:8], 1'b0, 4'h0, 2'b10, 1'b0};
   wire [20:0] unp_addr = addr_q | 21'h009002;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr <= 21'h0;
         flash_dq_o <= 8'h00;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         hv_ce <= 1'b0;
         hv_oe <= 1'b0;
         hv_a9 <= 1'b0;
      end else begin
         // address and chip enable stay stable through protect
         flash_addr <= (op_q == op_verify) ? vfy_addr :
            (op_q == op_unprotect) ? unp_addr :
            (is_read || is_hv) ? addr_q : s.addr;
         flash_dq_o <= s.data;
         flash_dq_oe <= busy && !is_read && !is_hv &&
            state_q != st_poll;
         flash_ce_n <= !(busy && op_q != op_unprotect);
         // one high cycle per poll round makes a fresh status read
         flash_oe_n <= !((state_q == st_poll && tmr_q != `T_STROBE) ||
            (is_read && state_q == st_strobe));
         flash_we_n <= !(state_q == st_strobe && !is_read);
         // high level held for the whole procedure
         hv_oe <= busy && is_hv;
         hv_a9 <= busy && (is_hv || op_q == op_verify);
         hv_ce <= busy && op_q == op_unprotect;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= 4'h0;
         addr_q <= 21'h0;
         wdata_q <= 8'h00;
         blkcnt_q <= 4'd0;
         rdata_q <= 8'h00;
         prev_q <= 8'h00;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         if (go) begin
            op_q <= avs_writedata[`CTRL_OP_HI:`CTRL_OP_LO];
            blkcnt_q <= avs_writedata[`CTRL_BLKCNT_HI:`CTRL_BLKCNT_LO];
            done_q <= 1'b0;
            err_q <= 1'b0;
         end
         if (avs_write && avs_address == `REG_ADDR)
            addr_q <= avs_writedata[20:0];
         if (avs_write && avs_address == `REG_WDATA)
            wdata_q <= avs_writedata[7:0];
         // next queued block, one per sixth-step repeat
         if (state_q == st_next && more_blks && idx_q >= 4'd5) begin
            blkcnt_q <= blkcnt_q - 4'd1;
            addr_q <= addr_q + 21'h010000;
         end
         if (state_q == st_strobe && tmr_zero && is_read)
            rdata_q <= dq_f_q;
         if (state_q == st_poll && tmr_zero)
            prev_q <= dq_f_q;
         if (state_q == st_next)
            prev_q <= dq_f_q;
         if (state_q == st_done) begin
            done_q <= 1'b1;
            err_q <= (state_q == st_done) && poll_fail;
            if (op_q == op_verify)
               rdata_q <= dq_f_q;
         end
      end
   end

   // sticky events: done, error, protected-on-verify, refused start
   wire [3:0] ev = {go_refused,
      state_q == st_done && op_q == op_verify &&
         dq_f_q == `VFY_PROTECTED,
      state_q == st_done && poll_fail, state_q == st_done};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 4'h0;
         mask_q <= 4'h0;
         ack_q <= 1'b0;
         avs_readdata <= `RESET_VAL;
      end else begin
         // set wins over the write-one clear
         irq_q <= (irq_q & ~((avs_write && avs_address == `REG_IRQ) ?
            avs_writedata[3:0] : 4'h0)) | ev;
         if (avs_write && avs_address == `REG_MASK)
            mask_q <= avs_writedata[3:0];
         ack_q <= avs_read && !ack_q;
         if (avs_read && !ack_q) begin
            unique case (avs_address)
               `REG_CTRL: avs_readdata <= {20'h0, blkcnt_q, 3'h0,
                  op_q, 1'b0};
               `REG_ADDR: avs_readdata <= {11'h0, addr_q};
               `REG_WDATA: avs_readdata <= {24'h0, wdata_q};
               `REG_STATUS: avs_readdata <= {24'h0, prev_q[`ST_ETIMER],
                  4'h0, err_q, done_q, busy};
               `REG_RDATA: avs_readdata <= {24'h0, rdata_q};
               `REG_IRQ: avs_readdata <= {28'h0, irq_q};
               `REG_MASK: avs_readdata <= {28'h0, mask_q};
               default: avs_readdata <= `RESET_VAL;
            endcase
            if (!hit)
               avs_readdata <= `RESET_VAL;
         end
      end
   end
   assign irq = |(irq_q & mask_q);

   property p_we_strobe;
      @(posedge core_clk) disable iff (!rst_n)
         $fell(flash_we_n) |-> !flash_ce_n || hv_ce;
   endproperty
   a_we_strobe: assert property (p_we_strobe)
      else $error("write strobe without chip select");
   property p_hv_stable;
      @(posedge core_clk) disable iff (!rst_n)
         (hv_oe && $past(hv_oe)) |-> $stable(flash_addr);
   endproperty
   a_hv_stable: assert property (p_hv_stable)
      else $error("address moved during protect");
   property p_unp_bits;
      @(posedge core_clk) disable iff (!rst_n)
         hv_ce |-> flash_addr[15] && flash_addr[12] && hv_a9 && hv_oe;
   endproperty
   a_unp_bits: assert property (p_unp_bits)
      else $error("unprotect pins wrong");
   property p_no_fight;
      @(posedge core_clk) disable iff (!rst_n)
         !flash_oe_n |-> !flash_dq_oe;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("data driven while device drives");
   property p_read_no_we;
      @(posedge core_clk) disable iff (!rst_n)
         !flash_oe_n |-> flash_we_n;
   endproperty
   a_read_no_we: assert property (p_read_no_we)
      else $error("write strobe during read");
   property p_protect_ce;
      @(posedge core_clk) disable iff (!rst_n)
         (hv_oe && !hv_ce) |-> !flash_ce_n && hv_a9;
   endproperty
   a_protect_ce: assert property (p_protect_ce)
      else $error("chip enable high during protect");
endmodule : flash_host
`default_nettype wire

// *** logic/flash_host_consts.svh ***
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
// register offsets (word addresses, one per register)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define REG_IRQ 4'h5
`define REG_MASK 4'h6
// ctrl fields
`define CTRL_GO 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 4
`define CTRL_BLKCNT_LO 8
`define CTRL_BLKCNT_HI 11
// addresses and data codes of the command sequences
`define UNLOCK_A1 11'h aaa
`define UNLOCK_A2 11'h555
`define CFI_ADDR 11'h0aa
`define D_UNLOCK1 8'haa
`define D_UNLOCK2 8'h55
`define D_RESET 8'hf0
`define D_AUTOSEL 8'h90
`define D_PROGRAM 8'ha0
`define D_BYPASS 8'h20
`define D_ERASE 8'h80
`define D_CHIPERASE 8'h10
`define D_BLKERASE 8'h30
`define D_SUSPEND 8'hb0
`define D_CFI 8'h98
`define D_BYP_EXIT 8'h00
// status polling bits
`define ST_POLL 7
`define ST_TOGGLE 6
`define ST_ERROR 5
`define ST_ETIMER 3
// protect verify
`define VFY_PROTECTED 8'h01
// bus cycle timing in core clocks
`define T_SETUP 3'd2
`define T_STROBE 3'd7
`define RESET_VAL 32'h0000_0000
`endif

// *** logic/flash_host_pkg.sv ***
package flash_host_pkg;
   typedef enum logic [3:0] {
      op_reset = 4'h0, op_reset3 = 4'h1, op_autosel = 4'h2,
      op_program = 4'h3, op_bypass = 4'h4, op_byp_prog = 4'h5,
      op_byp_exit = 4'h6, op_chip_erase = 4'h7, op_blk_erase = 4'h8,
      op_suspend = 4'h9, op_resume = 4'ha, op_cfi = 4'hb,
      op_read = 4'hc, op_verify = 4'hd, op_protect = 4'he,
      op_unprotect = 4'hf
   } op_t;
   typedef enum logic [2:0] {
      st_idle = 3'b000, st_setup = 3'b001, st_strobe = 3'b011,
      st_next = 3'b010, st_poll = 3'b110, st_done = 3'b111
   } state_t;
endpackage : flash_host_pkg

// *** logic/flash_seq_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface flash_seq_if;
   logic [3:0] idx;
   logic [3:0] op;
   logic [20:0] tgt;
   logic [7:0] val;
   logic [20:0] addr;
   logic [7:0] data;
   logic last;
   modport rom (input idx, input op, input tgt, input val,
      output addr, output data, output last);
   modport seq (output idx, output op, output tgt, output val,
      input addr, input data, input last);
endinterface : flash_seq_if
`default_nettype wire

// *** logic/flash_cmd_rom.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_cmd_rom
   import flash_host_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic rst_n, // async reset
   flash_seq_if.rom s // step lookup
);
   logic [20:0] addr_d;
   logic [7:0] data_d;
   logic last_d;
   op_t op;
   assign op = op_t'(s.op);
   function automatic logic [20:0] ua(input logic [10:0] a);
      ua = {10'h000, a};
   endfunction : ua
   always_comb begin
      addr_d = ua(`UNLOCK_A1);
      data_d = `D_UNLOCK1;
      last_d = 1'b0;
      unique case (op)
         op_reset, op_suspend, op_resume: begin
            data_d = (op == op_reset) ? `D_RESET :
               (op == op_suspend) ? `D_SUSPEND : `D_BLKERASE;
            last_d = 1'b1;
         end
         op_cfi: begin
            addr_d = ua(`CFI_ADDR);
            data_d = `D_CFI;
            last_d = 1'b1;
         end
         op_byp_prog: begin
            addr_d = (s.idx == 4'd0) ? 21'h0 : s.tgt;
            data_d = (s.idx == 4'd0) ? `D_PROGRAM : s.val;
            last_d = (s.idx == 4'd1);
         end
         op_byp_exit: begin
            data_d = (s.idx == 4'd0) ? `D_AUTOSEL : `D_BYP_EXIT;
            last_d = (s.idx == 4'd1);
         end
         default: begin
            // unlock prefix shared by every long command
            unique case (s.idx)
               4'd0, 4'd3: begin
                  addr_d = ua(`UNLOCK_A1);
                  data_d = `D_UNLOCK1;
               end
               4'd1, 4'd4: begin
                  addr_d = ua(`UNLOCK_A2);
                  data_d = `D_UNLOCK2;
               end
               4'd2: begin
                  addr_d = ua(`UNLOCK_A1);
                  unique case (op)
                     op_reset3: data_d = `D_RESET;
                     op_autosel: data_d = `D_AUTOSEL;
                     op_program: data_d = `D_PROGRAM;
                     op_bypass: data_d = `D_BYPASS;
                     default: data_d = `D_ERASE;
                  endcase
                  last_d = (op == op_reset3) || (op == op_autosel) ||
                     (op == op_bypass);
               end
               default: begin
                  // idx 5+ for erase; program idx 3 is set after this case
                  addr_d = (op == op_chip_erase) ? ua(`UNLOCK_A1) : s.tgt;
                  data_d = (op == op_program) ? s.val :
                     (op == op_chip_erase) ? `D_CHIPERASE : `D_BLKERASE;
                  last_d = 1'b1;
               end
            endcase
            if (op == op_program && s.idx == 4'd3) begin
               addr_d = s.tgt;
               data_d = s.val;
               last_d = 1'b1;
            end
         end
      endcase
   end
   // registered so the data outputs come from flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.addr <= 21'h0;
         s.data <= 8'h00;
         s.last <= 1'b0;
      end else begin
         s.addr <= addr_d;
         s.data <= data_d;
         s.last <= last_d;
      end
   end
endmodule : flash_cmd_rom
`default_nettype wire

// *** tb/flash_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter int WIN_NS = 50000, // block select window
   parameter int BUSY_READS = 3, // status reads per operation
   parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
   parameter logic [7:0] CFI_BYTE = 8'h3c // arbitrary value
)(
   input wire logic [20:0] addr, // address incl. byte lsb
   input wire logic [7:0] dq_in, // data line level
   input wire logic dq_oe, // host drives data
   input wire logic ce_n, // chip enable
   input wire logic oe_n, // output enable
   input wire logic we_n, // write enable
   input wire logic hv_ce, // high level on chip enable
   input wire logic hv_oe, // high level on output enable
   input wire logic hv_a9, // high level on A9
   output logic [7:0] dq_out // data to host
);
   typedef enum {m_read, m_auto, m_cfi, m_byp, m_busy} mode_t;
   logic [7:0] mem [int];
   logic [31:0] prot_q = '0;
   logic [31:0] ers_blk = '0;
   mode_t mode = m_read, back = m_read, cfi_back = m_read;
   int st = 0, busy_left = 0, last_len = 0;
   logic [7:0] last_cmd = 8'h00, poll7 = 8'h00, last_q = 8'h00;
   logic tgl = 1'b0, etimer = 1'b0, erasing = 1'b0, susp = 1'b0;
   time win_end = 0;

   function automatic logic [7:0] rd_arr(input logic [20:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
   endfunction : rd_arr

   task automatic note(input int n, input logic [7:0] d);
      last_len = n;
      last_cmd = d;
      st = 0;
   endtask : note

   task automatic wipe();
      int ks[$];
      foreach (mem[k]) if (ers_blk[k[20:16]] && !prot_q[k[20:16]])
         ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
   endtask : wipe

   task automatic prog(input logic [20:0] a, input logic [7:0] d);
      if (!prot_q[a[20:16]]) mem[int'(a)] = rd_arr(a) & d;
      poll7 = ~d;
      erasing = 1'b0;
      back = mode;
      mode = m_busy;
      busy_left = BUSY_READS;
   endtask : prog

   task automatic erase(input logic [31:0] blks, input logic now);
      ers_blk = blks;
      erasing = 1'b1;
      etimer = now;
      win_end = $time + WIN_NS;
      back = m_read;
      mode = m_busy;
      busy_left = BUSY_READS;
      if (now) wipe();
   endtask : erase

   task automatic cmd(input logic [20:0] a, input logic [7:0] d);
      logic a1, a2;
      // only low address bits and low data byte
      a1 = a[10:0] == `UNLOCK_A1;
      a2 = a[10:0] == `UNLOCK_A2;
      if (mode == m_busy) begin
         // more blocks only before the timer closes
         if (erasing && !etimer && d == `D_BLKERASE) begin
            ers_blk[a[20:16]] = 1'b1;
            win_end = $time + WIN_NS;
            note(last_len + 1, d);
         end else if (erasing && d == `D_SUSPEND) begin
            susp = 1'b1;
            mode = m_read;
            note(1, d);
         end
         return;
      end
      case (st)
         0: begin
            // reset, cfi falls back to previous mode
            if (d == `D_RESET) begin
               mode = (mode == m_cfi) ? cfi_back : m_read;
               note(1, d);
            // bypass takes program, reset or the autoselect-then-exit pair only
            end else if (mode == m_byp) begin
               st = (d == `D_PROGRAM) ? 8 : (d == `D_AUTOSEL) ? 7 : 0;
            end else if (d == `D_SUSPEND || d == `D_BLKERASE) begin
               if (susp && d == `D_BLKERASE) begin
                  susp = 1'b0;
                  mode = m_busy;
               end
               note(1, d);
            end else if (d == `D_CFI && a[10:0] == `CFI_ADDR &&
               (mode == m_read || mode == m_auto)) begin
               cfi_back = mode;
               mode = m_cfi;
               note(1, d);
            end else if (d == `D_UNLOCK1 && a1) st = 1;
         end
         // broken prefix goes back to the first cycle
         1: st = (d == `D_UNLOCK2 && a2) ? 2 : 0;
         2: begin
            if (d == `D_RESET) begin
               mode = m_read;
               note(3, d);
            end else if (!a1) st = 0;
            else if (d == `D_AUTOSEL) begin
               mode = m_auto;
               note(3, d);
            end else if (d == `D_BYPASS) begin
               mode = m_byp;
               note(3, d);
            end else if (d == `D_PROGRAM) st = 9;
            else st = (d == `D_ERASE) ? 3 : 0;
         end
         3: st = (d == `D_UNLOCK1 && a1) ? 4 : 0;
         4: st = (d == `D_UNLOCK2 && a2) ? 5 : 0;
         5: begin
            note(6, d);
            if (d == `D_CHIPERASE && a1) erase('1, 1'b1);
            else if (d == `D_BLKERASE) erase(32'h1 << a[20:16], 1'b0);
         end
         7: if (d == `D_BYP_EXIT) begin
            mode = m_read;
            note(2, d);
         end else st = 0;
         8: begin
            note(2, d);
            prog(a, d);
         end
         9: begin
            note(4, d);
            prog(a, d);
         end
         default: st = 0;
      endcase
   endtask : cmd

   // data must be driven by the host when the write strobe rises
   always @(posedge we_n)
      if (!ce_n && dq_oe && !hv_oe && !hv_ce) cmd(addr, dq_in);

   // protect one block, or clear all once all protected
   always @(posedge we_n) begin
      if (hv_oe && hv_a9 && !hv_ce && !ce_n) prot_q[addr[20:16]] = 1'b1;
      else if (hv_oe && hv_a9 && hv_ce && addr[15] && addr[12] && &prot_q)
         prot_q = '0;
   end

   always #100 if (erasing && !etimer && !susp && $time >= win_end) begin
      etimer = 1'b1;
      wipe();
   end

   // each busy read toggles; counts down unless the erase timer is still open
   always @(negedge oe_n) if (!ce_n && mode == m_busy) begin
      tgl = ~tgl;
      if (!erasing || etimer) busy_left = busy_left - 1;
      if (busy_left <= 0) mode = back;
   end

   always @* begin
      if (ce_n || oe_n) dq_out = ~last_q;
      // verify: A6 low, A1 high, A0 low (bit 0 is the byte lsb)
      else if (hv_a9) dq_out = (!addr[7] && addr[2] && !addr[1]) ?
         {7'h00, prot_q[addr[20:16]]} : ~last_q;
      else if (mode == m_busy)
         dq_out = {poll7[7] & ~erasing, tgl, 2'b00, etimer, 3'b000};
      else if (mode == m_auto) dq_out = MAKER_ID;
      else if (mode == m_cfi) dq_out = CFI_BYTE;
      else dq_out = rd_arr(addr);
   end

   // released line shows the inverse, never a stale value
   always @(dq_out) if (!ce_n && !oe_n) last_q = dq_out;
endmodule : flash_dev_model
`default_nettype wire

// *** tb/flash_host_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module flash_host_bench import flash_host_pkg::*;;
   typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
   note_t expq[$];
   logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, rv;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest, irq, flash_dq_oe, flash_ce_n, flash_oe_n;
   wire logic flash_we_n, hv_ce, hv_oe, hv_a9;
   wire logic [20:0] flash_addr;
   wire logic [7:0] flash_dq_o, flash_dq_i, dq_dev;
   int err_count = 0, tests_run = 0;
   logic [20:0] pa, qa;
   logic [7:0] pd;
   logic [3:0] rz [5] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'hf};
   op_t tops [8] = '{op_reset, op_reset3, op_autosel, op_reset, op_bypass,
      op_byp_exit, op_suspend, op_resume};
   int tlen [8] = '{1, 3, 3, 1, 3, 2, 1, 1};
   logic [7:0] tcode [8] = '{8'hf0, 8'hf0, 8'h90, 8'hf0, 8'h20, 8'h00,
      8'hb0, 8'h30};

   always #5 core_clk = ~core_clk;
   assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_dev;

   flash_host DUT (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .flash_addr,
      .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n,
      .flash_we_n, .hv_ce, .hv_oe, .hv_a9);
   flash_dev_model #(.WIN_NS(5000), .MAKER_ID(8'h5a), .CFI_BYTE(8'h3c)) mdl (
      .addr(flash_addr), .dq_in(flash_dq_i), .dq_oe(flash_dq_oe),
      .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .hv_ce,
      .hv_oe, .hv_a9, .dq_out(dq_dev));

   task automatic fail(input string s);
      err_count++;
      $display("mismatch %0t %s", $time, s);
   endtask : fail
   task automatic cmp_rd(input logic [31:0] g, input note_t n);
      tests_run++;
      if ((g & n.m) !== (n.e & n.m)) fail("register read");
   endtask : cmp_rd
   task automatic cmp_dev(input int el, input logic [7:0] ec);
      tests_run++;
      if (mdl.last_len != el || mdl.last_cmd !== ec) fail("command seen");
   endtask : cmp_dev
   task automatic cmp_bit(input logic e);
      tests_run++;
      if (irq !== e) fail("interrupt level");
   endtask : cmp_bit

   // oldest note is matched against each completed read
   always @(posedge core_clk) if (avs_read === 1'b1 &&
      avs_waitrequest === 1'b0 && expq.size() > 0) begin
      if (expq[0].m !== 32'h0) cmp_rd(avs_readdata, expq[0]);
      void'(expq.pop_front());
   end

   // idle edge first, so a strobe is never lowered and raised together
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, input logic [31:0] e,
      input logic [31:0] m);
      @(posedge core_clk);
      expq.push_back('{e, m});
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rv = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd
   task automatic wait_done();
      repeat (3000) begin
         bus_rd(4'h3, 32'h0, 32'h0);
         if (rv[1:0] === 2'b10) break;
      end
      if (rv[1:0] !== 2'b10) fail("no completion");
   endtask : wait_done
   task automatic run_op(input op_t op, input logic [20:0] a,
      input logic [7:0] d, input logic [3:0] n);
      bus_wr(4'h1, {11'h0, a});
      bus_wr(4'h2, {24'h0, d});
      bus_wr(4'h0, {20'h0, n, 3'h0, op, 1'b1});
      wait_done();
      bus_wr(4'h5, 32'h0000000f);
   endtask : run_op
   task automatic rd_flash(input op_t op, input logic [20:0] a,
      input logic [7:0] e);
      run_op(op, a, 8'h00, 4'h0);
      bus_rd(4'h4, {24'h0, e}, 32'h000000ff);
   endtask : rd_flash

   task automatic test_done();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   initial begin
      #900_000;
      err_count++;
      test_done();
   end

   initial begin
      void'($urandom(97));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rz[i]) bus_rd(rz[i], 32'h0, 32'hffffffff);
      foreach (tops[i]) begin
         run_op(tops[i], 21'h0, 8'h00, 4'h0);
         cmp_dev(tlen[i], tcode[i]);
      end
      run_op(op_autosel, 21'h0, 8'h00, 4'h0);
      rd_flash(op_read, 21'h0, 8'h5a);
      run_op(op_cfi, 21'h0, 8'h00, 4'h0);
      rd_flash(op_read, 21'h0, 8'h3c);
      run_op(op_reset, 21'h0, 8'h00, 4'h0);
      rd_flash(op_read, 21'h0, 8'h5a);
      run_op(op_reset, 21'h0, 8'h00, 4'h0);
      pa = {5'd1, 16'($urandom)};
      qa = {5'd3, pa[15:0]};
      pd = 8'($urandom);
      run_op(op_program, pa, pd, 4'h0);
      cmp_dev(4, pd);
      rd_flash(op_read, pa, pd);
      run_op(op_bypass, 21'h0, 8'h00, 4'h0);
      run_op(op_byp_prog, pa ^ 21'h1, ~pd, 4'h0);
      run_op(op_byp_prog, qa, pd, 4'h0);
      cmp_dev(2, pd);
      run_op(op_byp_exit, 21'h0, 8'h00, 4'h0);
      rd_flash(op_read, pa ^ 21'h1, ~pd);
      rd_flash(op_read, qa, pd);
      run_op(op_protect, 21'h020000, 8'h00, 4'h0);
      rd_flash(op_verify, 21'h020000, 8'h01);
      rd_flash(op_verify, 21'h030000, 8'h00);
      run_op(op_program, 21'h020010, 8'h00, 4'h0);
      rd_flash(op_read, 21'h020010, 8'hff);
      run_op(op_blk_erase, 21'h010000, 8'h00, 4'h1);
      cmp_dev(7, 8'h30);
      rd_flash(op_read, pa ^ 21'h1, 8'hff);
      rd_flash(op_read, qa, pd);
      // refused second start; refused bit masked at first, then unmasked alone
      bus_wr(4'h0, {27'h0, op_read, 1'b1});
      bus_wr(4'h0, {27'h0, op_read, 1'b1});
      wait_done();
      cmp_bit(1'b0);
      bus_wr(4'h6, 32'h00000008);
      bus_rd(4'h5, 32'h00000009, 32'h0000000b);
      cmp_bit(1'b1);
      bus_wr(4'h5, 32'h0000000f);
      bus_rd(4'h5, 32'h0, 32'h0000000f);
      cmp_bit(1'b0);
      for (int b = 0; b < 32; b++) run_op(op_protect, 21'(b << 16), 8'h00, 4'h0);
      run_op(op_unprotect, 21'h0, 8'h00, 4'h0);
      rd_flash(op_verify, 21'h020000, 8'h00);
      run_op(op_chip_erase, 21'h0, 8'h00, 4'h0);
      cmp_dev(6, 8'h10);
      rd_flash(op_read, qa, 8'hff);
      test_done();
   end
endmodule : flash_host_bench
`default_nettype wire
